//--- common/gpc_pkg.sv
// Purpose: Shared constants and types for the graphics port config registers
// Assumes: Byte offsets in configuration space, dword-wide accesses
// Notes:   Capability item base is a fixed local choice
package gpc_pkg;

  // Offsets in configuration space (bytes)
  localparam logic [7:0] STATUS_WORD_OFS = 8'h06;
  localparam logic [7:0] FIRST_ITEM_OFFSET_OFS     = 8'h34;
  localparam logic [7:0] CAP_BASE_OFS    = 8'h40;
  localparam logic [7:0] PORT_STAT_REL   = 8'h04;
  localparam logic [7:0] PORT_CMD_REL    = 8'h08;

  // Field positions
  localparam int CHAIN_PRESENT_BIT = 4;
  localparam int NEW_MODE_BIT      = 3;
  localparam int MAJOR_LSB         = 20;
  localparam int MINOR_LSB         = 16;
  localparam int NEXT_LSB          = 8;
  localparam int DEPTH_LSB         = 24;
  localparam int REQ_SIZE_LSB      = 13;
  localparam int CAL_LSB           = 10;
  localparam int SIDEBAND_BIT      = 9;
  localparam int PORT_EN_BIT       = 8;
  localparam int HIGH_ADDR_BIT     = 5;
  localparam int FAST_WRITE_BIT    = 4;

  // Identity values
  localparam logic [3:0] MAJOR_REV        = 4'h3;
  localparam logic [3:0] MINOR_REV        = 4'h0;
  localparam logic [7:0] CAP_CODE_HOST    = 8'h02;
  // Arbitrary value, stands in for the bridge-function code
  localparam logic [7:0] CAP_CODE_BRIDGE  = 8'hA5;
  localparam logic [7:0] NEXT_ITEM_RESET  = 8'h00;

  // Rate codes in new signaling mode
  localparam logic [2:0] RATE_4X   = 3'h1;
  localparam logic [2:0] RATE_8X   = 3'h2;
  localparam logic [2:0] RATE_BOTH = 3'h3;
  localparam logic [2:0] CAL_OFF   = 3'h7;

  // Command register contents
  typedef struct packed {
    logic [7:0] request_queue_depth;
    logic [2:0] programmed_request_size;
    logic [2:0] programmed_calibration_period;
    logic       sideband_address_enable;
    logic       port_operation_enable;
    logic       high_address_enable;
    logic       fast_write_enable;
    logic [2:0] selected_rate_field;
  } gpc_cmd_t;

  localparam gpc_cmd_t CMD_RESET = '0;

  // Command word layout, reserved bits zero
  function automatic logic [31:0] gpc_cmd_word(input gpc_cmd_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[DEPTH_LSB +: 8]    = c.request_queue_depth;
    w[REQ_SIZE_LSB +: 3] = c.programmed_request_size;
    w[CAL_LSB +: 3]      = c.programmed_calibration_period;
    w[SIDEBAND_BIT]      = c.sideband_address_enable;
    w[PORT_EN_BIT]       = c.port_operation_enable;
    w[HIGH_ADDR_BIT]     = c.high_address_enable;
    w[FAST_WRITE_BIT]    = c.fast_write_enable;
    w[2:0]               = c.selected_rate_field;
    return w;
  endfunction : gpc_cmd_word

  // Byte-lane merge of a write into a dword
  function automatic logic [31:0] gpc_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : gpc_merge

endpackage : gpc_pkg

//--- logic/gpc_op_gate.sv
// Purpose: Gates port operations on the enable bit
// Assumes: Arrival, completion and side-band strobes are on i_mclk
// Notes:   Work taken while enabled finishes after the enable drops
`timescale 1ns/10ps
module gpc_op_gate (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_port_en,
  // Operation stream
  input  wire logic i_op_arrive,
  input  wire logic i_op_done,
  output logic      o_op_accept,
  output logic      o_op_pending,
  // Side-band command
  input  wire logic i_sba_start,
  input  wire logic i_sba_end,
  output logic      o_sba_active
);

  logic [8:0] pend_q;
  logic       sba_q;
  logic       take;
  logic       fin;

  assign take        = i_op_arrive & i_port_en; // R16
  assign fin         = i_op_done & (pend_q != 9'h000);
  assign o_op_accept = take;

  // Count rises only while enabled, drains on completions regardless of enable
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 9'h000;
    end else if (take && !fin) begin
      pend_q <= pend_q + 9'h001; // R18
    end else if (fin && !take) begin
      pend_q <= pend_q - 9'h001;
    end
  end

  // Started side-band command runs to its end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sba_q <= 1'b0;
    end else if (i_sba_start && i_port_en) begin
      sba_q <= 1'b1;
    end else if (i_sba_end) begin
      sba_q <= 1'b0; // R18
    end
  end

  assign o_op_pending = (pend_q != 9'h000);
  assign o_sba_active = sba_q;

endmodule : gpc_op_gate

//--- logic/gpc_regs.sv
// Purpose: Configuration registers of a point-to-point graphics port
// Assumes: Dword config accesses with byte enables, one clock domain
// Notes:   Role and bridge location fixed by parameters
//
// What this block does
// R1 - Every field has a read, write and default class.
// R2 - Status word bit 4 reads set, writes ignored: capability list exists.
// R3 - Byte at 34h gives offset of the first capability item, read only.
// R4 - Identifier bits 31:24 read zero, writes ignored.
// R5 - Major revision 23:20 reads 0011, read only.
// R6 - Minor revision 19:16 reads 0000, read only.
// R7 - Bits 15:8 point to next item, zero for the last one.
// R8 - Bits 7:0 hold capability code, 02h in a host bridge.
// R9 - Status rate bits advertise 4x, 8x or both in new mode.
// R10 - With new mode clear, rate fields take legacy meanings.
// R11 - Master queue depth 31:24 read/write; target reads zero.
// R12 - Command reserved bits read zero, writes have no effect.
// R13 - Master bits 15:13 hold preferred request size code.
// R14 - Target bits 12:10 hold calibration period; master reads zero.
// R15 - Side-band enable bit 9 read/write, needed in new mode.
// R16 - Port enable bit 8 lets operations start or be accepted.
// R17 - Software sets enable last, target before master.
// R18 - Work already accepted still completes after enable clears.
// R19 - Port enable cleared by power-on reset.
// R20 - Bit 5 enables addressing above 4 GB.
// R21 - Bit 4 enables fast writes.
// R22 - Software sets one rate bit, same on both ends.
// R23 - Status bit 3 shows new signaling mode, fixed after reset.
`timescale 1ns/10ps
module gpc_regs #(
  parameter bit         IS_MASTER      = 1'b0,
  parameter bit         IN_HOST_BRIDGE = 1'b1,
  parameter logic [2:0] RATE_SUPPORT   = gpc_pkg::RATE_BOTH,
  parameter logic [7:0] NEXT_ITEM      = gpc_pkg::NEXT_ITEM_RESET
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Configuration access
  input  wire logic        i_cfg_rd,
  input  wire logic        i_cfg_wr,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_ack,
  // Mode detect and legacy rate pins
  input  wire logic        i_mode_detect_n,
  input  wire logic [2:0]  i_legacy_rate,
  // Operation stream from port logic
  input  wire logic        i_op_arrive,
  input  wire logic        i_op_done,
  input  wire logic        i_sba_start,
  input  wire logic        i_sba_end,
  output logic             o_op_accept,
  output logic             o_op_pending,
  output logic             o_sba_active,
  // Settings to port logic
  output gpc_pkg::gpc_cmd_t o_cmd,
  output logic             o_new_mode
);

  // Dword indices of the mapped registers
  localparam logic [5:0] DW_STATUS = gpc_pkg::STATUS_WORD_OFS[7:2];
  localparam logic [5:0] DW_CAPABILITY_LIST_POINTER = gpc_pkg::FIRST_ITEM_OFFSET_OFS[7:2];
  localparam logic [5:0] DW_IDENT  = gpc_pkg::CAP_BASE_OFS[7:2];
  localparam logic [7:0] STAT_OFS  = gpc_pkg::CAP_BASE_OFS + gpc_pkg::PORT_STAT_REL;
  localparam logic [7:0] CMD_OFS   = gpc_pkg::CAP_BASE_OFS + gpc_pkg::PORT_CMD_REL;
  localparam logic [5:0] DW_PSTAT  = STAT_OFS[7:2];
  localparam logic [5:0] DW_PCMD   = CMD_OFS[7:2];

  gpc_pkg::gpc_cmd_t cmd_q;
  gpc_pkg::gpc_cmd_t cmd_d;
  logic [31:0]       merged;
  logic [31:0]       rd_word;
  logic [31:0]       rdata_q;
  logic              ack_q;
  logic [5:0]        dw;
  logic [6:0]        pins_sync;
  logic [1:0]        settle_q;
  logic              mode_q;
  logic              mode_done_q;
  logic [2:0]        rate_adv;
  logic [7:0]        cap_code;

  assign dw = i_cfg_addr[7:2];

  // Pins pass two flops before use
  gpc_sync #(
    .WIDTH (7)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async ({i_legacy_rate, RATE_SUPPORT, i_mode_detect_n}),
    .o_sync  (pins_sync)
  );

  // Mode caught once after reset release, then frozen
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      settle_q    <= 2'h0;
      mode_q      <= 1'b0;
      mode_done_q <= 1'b0;
    end else if (!mode_done_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == 2'h2) begin
        mode_q      <= ~pins_sync[0]; // R23
        mode_done_q <= 1'b1;
      end
    end
  end

  // Advertised rate depends on the mode bit
  assign rate_adv = mode_q ? pins_sync[3:1] : pins_sync[6:4]; // R9 R10

  assign cap_code = IN_HOST_BRIDGE ? gpc_pkg::CAP_CODE_HOST
                                   : gpc_pkg::CAP_CODE_BRIDGE; // R8

  assign merged = gpc_pkg::gpc_merge(gpc_pkg::gpc_cmd_word(cmd_q),
                                     i_cfg_wdata, i_cfg_be);

  // Next command value, role masks applied
  always_comb begin
    cmd_d = cmd_q;
    if (i_cfg_wr && dw == DW_PCMD) begin
      cmd_d.request_queue_depth =
        IS_MASTER ? merged[gpc_pkg::DEPTH_LSB +: 8] : 8'h00; // R11
      cmd_d.programmed_request_size =
        IS_MASTER ? merged[gpc_pkg::REQ_SIZE_LSB +: 3] : 3'h0; // R13
      cmd_d.programmed_calibration_period =
        IS_MASTER ? 3'h0 : merged[gpc_pkg::CAL_LSB +: 3]; // R14
      cmd_d.sideband_address_enable = merged[gpc_pkg::SIDEBAND_BIT]; // R15
      cmd_d.port_operation_enable   = merged[gpc_pkg::PORT_EN_BIT]; // R16
      cmd_d.high_address_enable     = merged[gpc_pkg::HIGH_ADDR_BIT]; // R20
      cmd_d.fast_write_enable       = merged[gpc_pkg::FAST_WRITE_BIT]; // R21
      cmd_d.selected_rate_field     = merged[2:0]; // R10
    end
  end

  // Command register; reserved bits never stored
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= gpc_pkg::CMD_RESET; // R19 R1
    end else begin
      cmd_q <= cmd_d; // R12
    end
  end

  // Read mux; unmapped dwords read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (dw)
      DW_STATUS: begin
        rd_word[16 + gpc_pkg::CHAIN_PRESENT_BIT] = 1'b1; // R2
      end
      DW_CAPABILITY_LIST_POINTER: begin
        rd_word[7:0] = gpc_pkg::CAP_BASE_OFS; // R3
      end
      DW_IDENT: begin
        rd_word[31:24] = 8'h00; // R4
        rd_word[gpc_pkg::MAJOR_LSB +: 4] = gpc_pkg::MAJOR_REV; // R5
        rd_word[gpc_pkg::MINOR_LSB +: 4] = gpc_pkg::MINOR_REV; // R6
        rd_word[gpc_pkg::NEXT_LSB +: 8]  = NEXT_ITEM; // R7
        rd_word[7:0] = cap_code; // R8
      end
      DW_PSTAT: begin
        rd_word[gpc_pkg::NEW_MODE_BIT] = mode_q; // R23
        rd_word[2:0] = rate_adv; // R9
      end
      DW_PCMD: begin
        rd_word = gpc_pkg::gpc_cmd_word(cmd_q); // R12
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after the request
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= i_cfg_rd | i_cfg_wr;
      if (i_cfg_rd) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign o_cfg_rdata = rdata_q;
  assign o_cfg_ack   = ack_q;

  // Side-band is mandatory in new mode even if software forgets
  always_comb begin
    o_cmd = cmd_q;
    o_cmd.sideband_address_enable = cmd_q.sideband_address_enable | mode_q; // R15
  end

  assign o_new_mode = mode_q;

  // Enable gating of operations
  gpc_op_gate u_gate (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_port_en    (cmd_q.port_operation_enable),
    .i_op_arrive  (i_op_arrive),
    .i_op_done    (i_op_done),
    .o_op_accept  (o_op_accept),
    .o_op_pending (o_op_pending),
    .i_sba_start  (i_sba_start),
    .i_sba_end    (i_sba_end),
    .o_sba_active (o_sba_active)
  );

endmodule : gpc_regs

//--- logic/gpc_sync.sv
// Purpose: Two-stage synchroniser for static pin levels
// Assumes: Inputs change rarely, bits need no mutual coherence
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module gpc_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : gpc_sync

//--- verification/gpc_regs_checker.sv
// Purpose: Port-level assertions for gpc_regs
// Assumes: Role follows the bound design's master parameter
// Notes:   Mode freeze checked once a settle counter saturates
`timescale 1ns/10ps
module gpc_regs_checker #(
  parameter bit IS_MASTER = 1'b0
) (
  // Clock and reset
  input wire logic              i_mclk,
  input wire logic              i_rst,
  // Config access
  input wire logic              i_cfg_rd,
  input wire logic              i_cfg_wr,
  input wire logic [7:0]        i_cfg_addr,
  input wire logic [31:0]       o_cfg_rdata,
  input wire logic              o_cfg_ack,
  // Port operations
  input wire logic              i_op_arrive,
  input wire logic              i_op_done,
  input wire logic              i_sba_start,
  input wire logic              i_sba_end,
  input wire logic              o_op_accept,
  input wire logic              o_op_pending,
  input wire logic              o_sba_active,
  input wire gpc_pkg::gpc_cmd_t o_cmd,
  input wire logic              o_new_mode
);
  // Command bits that must read zero, per role
  localparam logic [31:0] ZERO_MASK = IS_MASTER ? 32'h00FF_1CC8 : 32'hFFFF_E0C8;
  logic [2:0] cnt_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Saturates well after the mode capture edge
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  end
  AST_ACK: assert property ((i_cfg_rd || i_cfg_wr) |=> o_cfg_ack)
    else $error("missing config ack");
  AST_NOACK: assert property (!(i_cfg_rd || i_cfg_wr) |=> !o_cfg_ack)
    else $error("config ack without request");
  AST_CHAIN: assert property (i_cfg_rd && i_cfg_addr == 8'h04 |=> o_cfg_rdata[20])
    else $error("capability list flag clear");
  AST_CAPABILITY_LIST_POINTER: assert property (i_cfg_rd && i_cfg_addr == 8'h34 |=> o_cfg_rdata == 32'h40)
    else $error("first item offset wrong");
  AST_ID: assert property (i_cfg_rd && i_cfg_addr == 8'h40 |=> o_cfg_rdata[31:16] == 16'h30)
    else $error("identifier revision bits wrong");
  AST_RSVD: assert property (i_cfg_rd && i_cfg_addr == 8'h48 |=> (o_cfg_rdata & ZERO_MASK) == 0)
    else $error("command zero bits read set");
  AST_ACCEPT: assert property (o_op_accept == (i_op_arrive && o_cmd.port_operation_enable))
    else $error("operation accept wrong");
  AST_PEND: assert property (o_op_accept && !i_op_done |=> o_op_pending)
    else $error("accepted operation not pending");
  AST_IDLE: assert property (!o_op_pending && !o_op_accept |=> !o_op_pending)
    else $error("pending without acceptance");
  AST_SBA: assert property (i_sba_start && o_cmd.port_operation_enable && !i_sba_end |=> o_sba_active)
    else $error("side-band command not active");
  AST_SBA_HOLD: assert property (o_sba_active && !i_sba_end |=> o_sba_active)
    else $error("side-band command dropped");
  AST_MODE: assert property (cnt_q == 3'h7 |-> $stable(o_new_mode))
    else $error("mode bit changed after reset");
  cover property (o_op_accept);
  cover property (o_sba_active && !o_cmd.port_operation_enable);
  cover property (o_cfg_ack && o_new_mode);
endmodule : gpc_regs_checker

//--- verification/tb_gpc_regs.sv
// Purpose: Self-checking bench for gpc_regs
// Assumes: Target in a host bridge, plus a master copy in a bridge function
// Notes:   Read results checked from a queue by a monitor
`timescale 1ns/10ps
module tb_gpc_regs;
  logic i_mclk = 0, i_rst = 1, i_cfg_rd = 0, i_cfg_wr = 0, i_mode_detect_n = 0;
  logic i_op_arrive = 0, i_op_done = 0, i_sba_start = 0, i_sba_end = 0;
  logic o_cfg_ack, o_op_accept, o_op_pending, o_sba_active, o_new_mode;
  logic [7:0]  i_cfg_addr = 8'h00;
  logic [3:0]  i_cfg_be = 4'h0, b;
  logic [2:0]  i_legacy_rate = 3'h5;
  logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata, d, cmd_exp, cmd_exp_m, lfsr_q = 32'hF061;
  logic [31:0] rdata_m;
  logic [64:0] note;
  logic [64:0] exp_q[$];
  gpc_pkg::gpc_cmd_t o_cmd;
  int fails = 0, tests_run = 0;
  logic [7:0]  ro_a[6] = '{8'h04, 8'h34, 8'h40, 8'h44, 8'h80, 8'h48};
  logic [31:0] ro_v[6] = '{32'h100000, 32'h40, 32'h300002, 32'hB, 32'h0, 32'h1F37};
  logic [31:0] ro_m[6] = '{32'h100000, 32'h40, 32'h3000A5, 32'hB, 32'h0, 32'hFF00E337};
  always #5 i_mclk = ~i_mclk;
  gpc_regs i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr),
    .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .i_mode_detect_n(i_mode_detect_n),
    .i_legacy_rate(i_legacy_rate), .i_op_arrive(i_op_arrive), .i_op_done(i_op_done),
    .i_sba_start(i_sba_start), .i_sba_end(i_sba_end), .o_op_accept(o_op_accept),
    .o_op_pending(o_op_pending), .o_sba_active(o_sba_active), .o_cmd(o_cmd),
    .o_new_mode(o_new_mode));
  // Master copy reaches the role-masked fields the target never stores
  gpc_regs #(.IS_MASTER(1'b1), .IN_HOST_BRIDGE(1'b0)) i_dut_m (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(rdata_m), .o_cfg_ack(),
    .i_mode_detect_n(i_mode_detect_n), .i_legacy_rate(i_legacy_rate),
    .i_op_arrive(i_op_arrive), .i_op_done(i_op_done), .i_sba_start(i_sba_start),
    .i_sba_end(i_sba_end), .o_op_accept(), .o_op_pending(), .o_sba_active(), .o_cmd(),
    .o_new_mode());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task cfg(input logic r, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
           input logic [31:0] e, input logic [31:0] em);
    @(posedge i_mclk) #1;
    {i_cfg_rd, i_cfg_wr, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {r, !r, a, be, wd};
    exp_q.push_back({r, em, e});
    @(posedge i_mclk) #1;
    {i_cfg_rd, i_cfg_wr} = 2'b00;
  endtask : cfg
  task op(input logic [3:0] p, input logic acc);
    @(posedge i_mclk) #1;
    {i_op_arrive, i_op_done, i_sba_start, i_sba_end} = p;
    #1 check({31'h0, o_op_accept}, {31'h0, acc});
    @(posedge i_mclk) #1;
    {i_op_arrive, i_op_done, i_sba_start, i_sba_end} = 4'h0;
  endtask : op
  task do_reset(input logic mode_n);
    @(posedge i_mclk) #1;
    {i_rst, i_mode_detect_n} = {1'b1, mode_n};
    repeat (3) @(posedge i_mclk);
    #1 i_rst = 0;
    repeat (6) @(posedge i_mclk);
  endtask : do_reset
  // Ack is one cycle wide, so sample it mid-cycle
  always @(negedge i_mclk) begin
    if (o_cfg_ack === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else begin
        note = exp_q.pop_front();
        if (note[64]) begin
          check(o_cfg_rdata, note[31:0]);
          check(rdata_m, note[63:32]);
        end
      end
    end
  end
  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      cfg(0, ro_a[i], 4'hF, 32'hFFFFFFFF, 0, 0);
      cfg(1, ro_a[i], 4'hF, 0, ro_v[i], ro_m[i]);
    end
    $display("read-only test done");
    cmd_exp = 32'h1F37;
    cmd_exp_m = 32'hFF00E337;
    for (int i = 0; i < 12; i++) begin
      lfsr_q = lfsr(lfsr_q);
      d = lfsr_q;
      b = lfsr_q[7:4];
      for (int k = 0; k < 4; k++) begin
        if (b[k]) begin
          cmd_exp[k*8 +: 8]   = d[k*8 +: 8];
          cmd_exp_m[k*8 +: 8] = d[k*8 +: 8];
        end
      end
      cmd_exp   = cmd_exp & 32'h1F37;
      cmd_exp_m = cmd_exp_m & 32'hFF00E337;
      cfg(0, 8'h48, b, d, 0, 0);
      cfg(1, 8'h48, 4'hF, 0, cmd_exp, cmd_exp_m);
    end
    $display("command test done");
    // Fields and one rate bit first, enable last in its own write
    cfg(0, 8'h48, 4'hF, 32'h201, 0, 0);
    check({11'h0, o_cmd}, 32'h41);
    op(4'b1000, 1'b0);
    check({30'h0, o_op_pending, o_sba_active}, 32'h0);
    cfg(0, 8'h48, 4'h2, 32'h300, 0, 0);
    check({11'h0, o_cmd}, 32'h61);
    op(4'b1010, 1'b1);
    check({30'h0, o_op_pending, o_sba_active}, 32'h3);
    cfg(0, 8'h48, 4'hF, 32'h0, 0, 0);
    check({11'h0, o_cmd}, 32'h40);
    op(4'b0000, 1'b0);
    check({30'h0, o_op_pending, o_sba_active}, 32'h3);
    op(4'b0101, 1'b0);
    check({30'h0, o_op_pending, o_sba_active}, 32'h0);
    $display("operation gate test done");
    i_mode_detect_n = 1;
    repeat (5) @(posedge i_mclk);
    cfg(1, 8'h44, 4'hF, 0, 32'hB, 32'hB);
    cfg(0, 8'h48, 4'hF, 32'hFFFFFFFF, 0, 0);
    do_reset(1'b1);
    cfg(1, 8'h48, 4'hF, 0, 32'h0, 32'h0);
    cfg(1, 8'h44, 4'hF, 0, {29'h0, i_legacy_rate}, {29'h0, i_legacy_rate});
    check({11'h0, o_cmd}, 32'h0);
    check({31'h0, o_new_mode}, 32'h0);
    $display("mode and reset test done");
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge i_mclk);
    if (exp_q.size() != 0) fails++;
    end_sim();
  end
endmodule : tb_gpc_regs
bind gpc_regs gpc_regs_checker #(.IS_MASTER(IS_MASTER)) i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_cfg_rd(i_cfg_rd),
  .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr), .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_ack(o_cfg_ack), .i_op_arrive(i_op_arrive), .i_op_done(i_op_done),
  .i_sba_start(i_sba_start), .i_sba_end(i_sba_end), .o_op_accept(o_op_accept),
  .o_op_pending(o_op_pending), .o_sba_active(o_sba_active), .o_cmd(o_cmd),
  .o_new_mode(o_new_mode));
